// file: rtl/pdm_map.vh
// register offsets, field layouts and reset values of the clock monitor block
`ifndef PDM_MAP_VH
`define PDM_MAP_VH
`define PDM_ADDR_W 8
`define PDM_DATA_W 8
`define PDM_OFS_PDIV 8'h60
`define PDM_OFS_JFAC 8'h61
`define PDM_OFS_DMSB 8'h62
`define PDM_OFS_DLSB 8'h63
`define PDM_OFS_RFAC 8'h64
`define PDM_OFS_DSPD 8'h65
`define PDM_OFS_DACD 8'h66
`define PDM_ZERO8 8'h00
`define PDM_RSV1_W 1
`define PDM_RSV2_W 2
`define PDM_RSV4_W 4
`define PDM_RSV1_RST 1'h0
`define PDM_RSV2_RST 2'h0
`define PDM_RSV4_RST 4'h0
`define PDM_D_MAX 14'h270f
`define PDM_J_ERR 6'h00
`define PDM_RST_P 7'h00
`define PDM_RST_J 6'h00
`define PDM_RST_D 14'h0000
`define PDM_RST_R 4'h0
`define PDM_RST_DIV 7'h00
`define PDM_DHI_MSB 13
`define PDM_DHI_LSB 8
`define PDM_DLO_MSB 5
`define PDM_DLO_LSB 0
`define PDM_REGS 7
`define PDM_IDX_W 3
`define PDM_IDX_PDIV 3'h0
`define PDM_IDX_JFAC 3'h1
`define PDM_IDX_DMSB 3'h2
`define PDM_IDX_DLSB 3'h3
`define PDM_IDX_RFAC 3'h4
`define PDM_IDX_DSPD 3'h5
`define PDM_IDX_DACD 3'h6
`define PDM_IDX_NONE 3'h7
`endif

// file: rtl/pdm_rsv_bank.v
// small register bank holding the reserved read/write bits of the monitor registers
`timescale 1ns/10ps
`include "pdm_map.vh"
module pdm_rsv_bank (
    clk,
    resetn,
    clk_en,
    wr_en,
    wr_idx,
    wr_data,
    rd_idx,
    rd_data
);
    input clk;
    input resetn;
    input clk_en;
    input wr_en;
    input [`PDM_IDX_W-1:0] wr_idx;
    input [`PDM_DATA_W-1:0] wr_data;
    input [`PDM_IDX_W-1:0] rd_idx;
    output [`PDM_DATA_W-1:0] rd_data;
    reg [`PDM_DATA_W-1:0] rd_data;
    reg [`PDM_DATA_W-1:0] mem_ff [0:`PDM_REGS-1];
    integer i;
    // write port, reset clears every reserved bit
    always @(posedge clk) begin
        if (!resetn) begin
            for (i = 0; i < `PDM_REGS; i = i + 1) begin
                mem_ff[i] <= `PDM_ZERO8;
            end
        end else if (clk_en && wr_en && (wr_idx != `PDM_IDX_NONE)) begin
            mem_ff[wr_idx] <= wr_data;
        end
    end
    // registered read port
    always @(posedge clk) begin
        if (!resetn) begin
            rd_data <= `PDM_ZERO8;
        end else if (clk_en) begin
            if (rd_idx == `PDM_IDX_NONE) begin
                rd_data <= `PDM_ZERO8;
            end else begin
                rd_data <= mem_ff[rd_idx];
            end
        end
    end
endmodule

// file: rtl/pdm_clk_monitor.v
// clock tree monitor registers: in-use pll factors and clock dividers
// Behaviour
// [R1] report in-use low D part, error flagged
// [R2] auto setup selects derived, else programmed value
// [R3] r factor field bits 3-0, code plus one
// [R4] dsp divider field bits 6-0, code plus one
// [R5] dac divider field bits 6-0, code plus one
// [R6] upper unused bits reserved read/write, reset zero
// [R7] j factor 6-bit, zero means error
// [R8] p prediv 7-bit, code plus one
// [R9] writes to monitor fields are ignored
`timescale 1ns/10ps
`include "pdm_map.vh"
module pdm_clk_monitor (
    clk,
    resetn,
    clk_en,
    auto_set_active,
    auto_p,
    auto_j,
    auto_d,
    auto_r,
    auto_dsp_div,
    auto_dac_div,
    prog_p,
    prog_j,
    prog_d,
    prog_r,
    prog_dsp_div,
    prog_dac_div,
    reg_addr,
    reg_wr,
    reg_rd,
    reg_wdata,
    reg_rdata,
    reg_rvalid,
    d_error,
    j_error
);
    input clk;
    input resetn;
    input clk_en;
    input auto_set_active;
    input [6:0] auto_p;
    input [5:0] auto_j;
    input [13:0] auto_d;
    input [3:0] auto_r;
    input [6:0] auto_dsp_div;
    input [6:0] auto_dac_div;
    input [6:0] prog_p;
    input [5:0] prog_j;
    input [13:0] prog_d;
    input [3:0] prog_r;
    input [6:0] prog_dsp_div;
    input [6:0] prog_dac_div;
    input [`PDM_ADDR_W-1:0] reg_addr;
    input reg_wr;
    input reg_rd;
    input [`PDM_DATA_W-1:0] reg_wdata;
    output [`PDM_DATA_W-1:0] reg_rdata;
    output reg_rvalid;
    output d_error;
    output j_error;

    // registered outputs
    reg [`PDM_DATA_W-1:0] reg_rdata;
    reg reg_rvalid;
    reg d_error;
    reg j_error;
    // in-use settings as captured
    reg [6:0] pll_prediv_view_ff;
    reg [5:0] pll_int_factor_view_ff;
    reg [13:0] pll_frac_factor_view_ff;
    reg [3:0] pll_r_factor_view_ff;
    reg [6:0] dsp_divide_view_ff;
    reg [6:0] dac_divide_view_ff;
    // read path state
    reg rd_pend_ff;
    reg [`PDM_IDX_W-1:0] rd_idx_ff;
    wire [`PDM_DATA_W-1:0] rsv_rdata;
    reg [`PDM_DATA_W-1:0] rsv_wmask;
    reg [`PDM_DATA_W-1:0] mon_word;
    wire [`PDM_IDX_W-1:0] acc_idx;
    // selected settings before capture, padded to the selector width
    wire [13:0] sel_p;
    wire [13:0] sel_j;
    wire [13:0] sel_d;
    wire [13:0] sel_r;
    wire [13:0] sel_dsp;
    wire [13:0] sel_dac;

    // offset to bank index decode, shared by read and write
    function [`PDM_IDX_W-1:0] addr_idx;
        input [`PDM_ADDR_W-1:0] a;
        begin
            case (a)
                `PDM_OFS_PDIV: addr_idx = `PDM_IDX_PDIV;
                `PDM_OFS_JFAC: addr_idx = `PDM_IDX_JFAC;
                `PDM_OFS_DMSB: addr_idx = `PDM_IDX_DMSB;
                `PDM_OFS_DLSB: addr_idx = `PDM_IDX_DLSB;
                `PDM_OFS_RFAC: addr_idx = `PDM_IDX_RFAC;
                `PDM_OFS_DSPD: addr_idx = `PDM_IDX_DSPD;
                `PDM_OFS_DACD: addr_idx = `PDM_IDX_DACD;
                default: addr_idx = `PDM_IDX_NONE;
            endcase
        end
    endfunction

    // auto or programmed selection of one value
    function [13:0] pick;
        input sel_auto;
        input [13:0] a;
        input [13:0] p;
        begin
            pick = sel_auto ? a : p;
        end
    endfunction

    assign acc_idx = addr_idx(reg_addr);

    // per-field choice between derived and programmed setting
    assign sel_p = pick(auto_set_active, {7'h00, auto_p}, {7'h00, prog_p}); // R2
    assign sel_j = pick(auto_set_active, {8'h00, auto_j}, {8'h00, prog_j}); // R2
    assign sel_d = pick(auto_set_active, auto_d, prog_d); // R2
    assign sel_r = pick(auto_set_active, {10'h000, auto_r}, {10'h000, prog_r}); // R2
    assign sel_dsp = pick(auto_set_active, {7'h00, auto_dsp_div}, {7'h00, prog_dsp_div}); // R2
    assign sel_dac = pick(auto_set_active, {7'h00, auto_dac_div}, {7'h00, prog_dac_div}); // R2

    // capture the setting actually applied in the clock tree
    always @(posedge clk) begin
        if (!resetn) begin
            pll_prediv_view_ff <= `PDM_RST_P;
            pll_int_factor_view_ff <= `PDM_RST_J;
            pll_frac_factor_view_ff <= `PDM_RST_D;
            pll_r_factor_view_ff <= `PDM_RST_R;
            dsp_divide_view_ff <= `PDM_RST_DIV;
            dac_divide_view_ff <= `PDM_RST_DIV;
        end else if (clk_en) begin
            pll_prediv_view_ff <= sel_p[6:0]; // R8
            pll_int_factor_view_ff <= sel_j[5:0]; // R7
            pll_frac_factor_view_ff <= sel_d; // R1
            pll_r_factor_view_ff <= sel_r[3:0]; // R3
            dsp_divide_view_ff <= sel_dsp[6:0]; // R4
            dac_divide_view_ff <= sel_dac[6:0]; // R5
        end
    end

    // reserved bit lanes that software may write
    always @* begin
        case (acc_idx)
            `PDM_IDX_PDIV: rsv_wmask = {{`PDM_RSV1_W{1'b1}}, 7'h00};
            `PDM_IDX_JFAC: rsv_wmask = {{`PDM_RSV2_W{1'b1}}, 6'h00};
            `PDM_IDX_DMSB: rsv_wmask = {{`PDM_RSV2_W{1'b1}}, 6'h00};
            `PDM_IDX_DLSB: rsv_wmask = {{`PDM_RSV2_W{1'b1}}, 6'h00};
            `PDM_IDX_RFAC: rsv_wmask = {{`PDM_RSV4_W{1'b1}}, 4'h0};
            `PDM_IDX_DSPD: rsv_wmask = {{`PDM_RSV1_W{1'b1}}, 7'h00};
            `PDM_IDX_DACD: rsv_wmask = {{`PDM_RSV1_W{1'b1}}, 7'h00};
            default: rsv_wmask = `PDM_ZERO8;
        endcase
    end

    // reserved bits stored apart, monitor lanes masked off on write
    pdm_rsv_bank u_rsv (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .wr_en(reg_wr), // R6 R9
        .wr_idx(acc_idx),
        .wr_data(reg_wdata & rsv_wmask), // R9
        .rd_idx(acc_idx),
        .rd_data(rsv_rdata)
    );

    // read pipeline: bank read lands one cycle after the request
    always @(posedge clk) begin
        if (!resetn) begin
            rd_pend_ff <= 1'b0;
            rd_idx_ff <= `PDM_IDX_NONE;
        end else if (clk_en) begin
            rd_pend_ff <= reg_rd;
            rd_idx_ff <= acc_idx;
        end
    end

    // monitor field placement per register
    always @* begin
        case (rd_idx_ff)
            `PDM_IDX_PDIV: mon_word = {1'b0, pll_prediv_view_ff}; // R8
            `PDM_IDX_JFAC: mon_word = {2'h0, pll_int_factor_view_ff}; // R7
            `PDM_IDX_DMSB: mon_word = {2'h0, pll_frac_factor_view_ff[`PDM_DHI_MSB:`PDM_DHI_LSB]};
            `PDM_IDX_DLSB: mon_word = {2'h0, pll_frac_factor_view_ff[`PDM_DLO_MSB:`PDM_DLO_LSB]}; // R1
            `PDM_IDX_RFAC: mon_word = {4'h0, pll_r_factor_view_ff}; // R3
            `PDM_IDX_DSPD: mon_word = {1'b0, dsp_divide_view_ff}; // R4
            `PDM_IDX_DACD: mon_word = {1'b0, dac_divide_view_ff}; // R5
            default: mon_word = `PDM_ZERO8;
        endcase
    end

    // read answer, data held until the next answer
    always @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= `PDM_ZERO8;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= rd_pend_ff;
            if (rd_pend_ff) begin
                reg_rdata <= mon_word | rsv_rdata; // R6
            end
        end
    end

    // error flags trail the captured settings by one cycle
    always @(posedge clk) begin
        if (!resetn) begin
            d_error <= 1'b0;
            j_error <= 1'b0;
        end else if (clk_en) begin
            d_error <= pll_frac_factor_view_ff > `PDM_D_MAX; // R1
            j_error <= pll_int_factor_view_ff == `PDM_J_ERR; // R7
        end
    end
endmodule

// file: bench/pdm_clk_monitor_monitor.sv
// assertion checker for the clock monitor register port
`timescale 1ns/10ps
module pdm_clk_monitor_chk (
    input logic clk,
    input logic resetn,
    input logic clk_en,
    input logic auto_set_active,
    input logic [13:0] auto_d,
    input logic [13:0] prog_d,
    input logic [5:0] auto_j,
    input logic [5:0] prog_j,
    input logic [3:0] auto_r,
    input logic [3:0] prog_r,
    input logic [7:0] reg_addr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    input logic reg_rvalid,
    input logic d_error,
    input logic j_error
);
    // settings in use, auto or programmed
    wire [13:0] sd = auto_set_active ? auto_d : prog_d;
    wire [5:0] sdl = sd[5:0];
    wire [5:0] sj = auto_set_active ? auto_j : prog_j;
    wire [3:0] sr = auto_set_active ? auto_r : prog_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // flags are two enabled cycles behind the selected setting
    sequence settled_s;
        $past(resetn) && $past(resetn, 2) && $past(clk_en) && $past(clk_en, 2);
    endsequence
    rd_answer_a: assert property (reg_rd && clk_en |-> ##2 reg_rvalid)
        else $error("read not answered");
    answer_cause_a: assert property (reg_rvalid |-> $past(reg_rd, 2))
        else $error("answer without read");
    rdata_hold_a: assert property (!reg_rvalid && $past(resetn) |-> $stable(reg_rdata))
        else $error("read data moved");
    d_flag_a: assert property (settled_s |-> d_error == ($past(sd, 2) > 14'h270f))
        else $error("d flag wrong");
    j_flag_a: assert property (settled_s |-> j_error == ($past(sj, 2) == 6'h00))
        else $error("j flag wrong");
    freeze_hold_a: assert property ($past(resetn) && !$past(clk_en)
        |-> $stable(reg_rdata) && $stable(reg_rvalid)
        && $stable(d_error) && $stable(j_error))
        else $error("frozen output moved");
    unmapped_zero_a: assert property (reg_rd && clk_en
        && (reg_addr < 8'h60 || reg_addr > 8'h66) |-> ##2 reg_rdata == 8'h00)
        else $error("unmapped not zero");
    r_field_a: assert property (reg_rd && clk_en && reg_addr == 8'h64
        |-> ##2 reg_rdata[3:0] == $past(sr, 2))
        else $error("r field wrong");
    d_low_a: assert property (reg_rd && clk_en && reg_addr == 8'h63
        |-> ##2 reg_rdata[5:0] == $past(sdl, 2))
        else $error("d low field wrong");
    cover property (!clk_en && reg_rd);
    cover property (reg_rvalid && reg_rdata[7]);
    cover property (d_error && j_error);
    cover property (!auto_set_active && reg_rd);
endmodule

// file: bench/pdm_clk_tree.sv
// clock tree model: boundary auto and programmed settings
`timescale 1ns/10ps
module pdm_clk_tree (
    output logic [6:0] auto_p,
    output logic [5:0] auto_j,
    output logic [13:0] auto_d,
    output logic [3:0] auto_r,
    output logic [6:0] auto_dsp_div,
    output logic [6:0] auto_dac_div,
    output logic [6:0] prog_p,
    output logic [5:0] prog_j,
    output logic [13:0] prog_d,
    output logic [3:0] prog_r,
    output logic [6:0] prog_dsp_div,
    output logic [6:0] prog_dac_div
);
    // auto set at top codes except dac divider at zero, programmed set at error and zero codes except dac divider at top code
    assign {auto_p, auto_j, auto_d, auto_r} = {7'h7f, 6'h3f, 14'h270f, 4'hf};
    assign {auto_dsp_div, auto_dac_div} = {7'h7f, 7'h00};
    assign {prog_p, prog_j, prog_d, prog_r} = {7'h00, 6'h00, 14'h2710, 4'h0};
    assign {prog_dsp_div, prog_dac_div} = {7'h00, 7'h7f};
endmodule

// file: bench/pdm_clk_monitor_tb.sv
// self-checking bench for the clock monitor registers
`timescale 1ns/10ps
module pdm_clk_monitor_tb;
    logic clk = 0, resetn = 0, clk_en = 1, auto_set_active = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, i;
    logic reg_rvalid, d_error, j_error;
    logic [6:0] auto_p, prog_p, auto_dsp_div, prog_dsp_div, auto_dac_div, prog_dac_div;
    logic [5:0] auto_j, prog_j;
    logic [13:0] auto_d, prog_d;
    logic [3:0] auto_r, prog_r;
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    logic [7:0] ea [7] = '{8'h7f, 8'h3f, 8'h27, 8'h0f, 8'h0f, 8'h7f, 8'h00};
    logic [7:0] ew [7] = '{8'hff, 8'hff, 8'he7, 8'hcf, 8'hff, 8'hff, 8'h80};
    logic [7:0] ep [7] = '{8'h80, 8'hc0, 8'he7, 8'hd0, 8'hf0, 8'h80, 8'hff};
    pdm_clk_monitor uut (.clk, .resetn, .clk_en, .auto_set_active, .auto_p, .auto_j, .auto_d,
        .auto_r, .auto_dsp_div, .auto_dac_div, .prog_p, .prog_j, .prog_d, .prog_r, .prog_dsp_div,
        .prog_dac_div, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
        .d_error, .j_error);
    pdm_clk_tree tree (.auto_p, .auto_j, .auto_d, .auto_r, .auto_dsp_div, .auto_dac_div,
        .prog_p, .prog_j, .prog_d, .prog_r, .prog_dsp_div, .prog_dac_div);
    always #25 clk = ~clk;
    // cycle ceiling against hangs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = 8'hff;
        reg_wr = 1;
        @(negedge clk);
        reg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        int n;
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1;
        @(negedge clk);
        reg_rd = 0;
        for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(negedge clk);
        chk("read valid", {7'h00, reg_rvalid}, 8'h01);
        chk($sformatf("reg %h", a), reg_rdata, e);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // reset, auto values, write-protect, programmed values
    initial begin
        repeat (20) @(negedge clk);
        resetn = 1;
        for (i = 0; i < 7; i++) rd(8'h60 + i, ea[i]);
        chk("error flags", {6'h0, d_error, j_error}, 8'h00);
        for (i = 0; i < 8; i++) wr(8'h60 + i);
        for (i = 0; i < 7; i++) rd(8'h60 + i, ew[i]);
        rd(8'h67, 8'h00);
        rd(8'h5f, 8'h00);
        auto_set_active = 0;
        repeat (4) @(negedge clk);
        for (i = 0; i < 7; i++) rd(8'h60 + i, ep[i]);
        chk("error flags", {6'h0, d_error, j_error}, 8'h03);
        // frozen enable: read not taken, flags hold while the mode flips
        @(negedge clk);
        clk_en = 0;
        auto_set_active = 1;
        reg_addr = 8'h64;
        reg_rd = 1;
        @(negedge clk);
        reg_rd = 0;
        @(negedge clk);
        chk("frozen valid", {7'h00, reg_rvalid}, 8'h00);
        chk("frozen flags", {6'h0, d_error, j_error}, 8'h03);
        clk_en = 1;
        repeat (4) @(negedge clk);
        chk("error flags", {6'h0, d_error, j_error}, 8'h00);
        // mid-run reset clears the reserved bits again
        resetn = 0;
        repeat (3) @(negedge clk);
        resetn = 1;
        for (i = 0; i < 7; i++) rd(8'h60 + i, ea[i]);
        conclude();
    end
endmodule
bind pdm_clk_monitor pdm_clk_monitor_chk chk (.clk, .resetn, .clk_en, .auto_set_active, .auto_d,
    .prog_d,
    .auto_j, .prog_j, .auto_r, .prog_r, .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid, .d_error,
    .j_error);
